// [rtl/ewp_dev_end.sv]
// Behaviour
// (RQ1) Soft locks guard 00h-7Fh; pin guards all
// (RQ2) Preamble 0110 write sets permanent lock
// (RQ3) No lock programming while protect pin high
// (RQ4) Controller waits out write cycle after commands
// (RQ5) Permanent lock set: never acknowledge 0110
// (RQ6) 62h with straps 0,0,HV sets reversible
// (RQ7) 66h with straps 0,1,HV clears reversible
// (RQ8) Protect pin high blocks every array write
// (RQ9) Pin low: permission from soft locks only
// (RQ10) Locked: acknowledge, commit upper half only
// (RQ11) Unlocked: acknowledge, commit whole array
// (RQ12) Permanent query: nack if set, else ack
// (RQ13) Permanent set: nack if set, else program
// (RQ14) Reversible query: nack if set, else ack
// (RQ15) Reversible set: nack if set, else program
// (RQ16) Reversible clear: nack if permanent set
// (RQ17) Blocked writes still ack and run cycle
// (RQ18) Pin high: lock commands ack, flags unchanged
// (RQ19) Address bits match straps; bit 0 reads
// (RQ20) HV detect input; flags in nonvolatile cells
// (RQ21) Floating protect pin behaves as low
`timescale 1ns/1ps
`default_nettype none
module ewp_dev_end #(
  parameter int WR_CYCLES = ewp_pkg::WR_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  ewp_link_if.dev link,
  input wire logic addr_strap_2,
  input wire logic addr_strap_1,
  input wire logic addr_strap_0,
  input wire logic addr_strap_0_hv,
  input wire logic wp_at_supply,
  input wire logic nv_perm_stored,
  input wire logic nv_rev_stored,
  output logic nv_we,
  output logic nv_perm_d,
  output logic nv_rev_d,
  output logic arr_we,
  output logic [7:0] arr_addr,
  output logic [7:0] arr_wdata,
  output logic permanent_soft_lock,
  output logic reversible_soft_lock
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic loaded_r; // Flags restored from cells
  logic loaded_nxt;
  logic perm_r; // Permanent lock copy
  logic perm_nxt;
  logic rev_r; // Reversible lock copy
  logic rev_nxt;
  logic rsp_valid_r; // Answer strobe
  logic rsp_valid_nxt;
  logic rsp_ack_r; // Answer acknowledge
  logic rsp_ack_nxt;
  logic arr_we_r; // Array write strobe
  logic arr_we_nxt;
  logic [7:0] arr_addr_r; // Array write address
  logic [7:0] arr_addr_nxt;
  logic [7:0] arr_wdata_r; // Array write data
  logic [7:0] arr_wdata_nxt;
  logic nv_we_r; // Cell program strobe
  logic nv_we_nxt;
  logic nv_perm_r; // Cell data, permanent
  logic nv_perm_nxt;
  logic nv_rev_r; // Cell data, reversible
  logic nv_rev_nxt;
  logic start; // Launch write cycle
  logic busy; // Write cycle running
  logic [3:0] pre; // Preamble field
  logic [2:0] adr; // Address field
  logic rd; // Read select
  logic strap_match; // Address field equals straps
  logic is_array; // Normal array access
  logic is_rev_set; // Reversible set or query
  logic is_rev_clr; // Reversible clear
  logic is_perm; // Permanent set or query
  logic wp_hi; // Hardware protect asserted
  logic lock_any; // Either soft lock

  ////////////////////////////////////////////////////////////////////////////
  // Write cycle timer
  ewp_wr_timer #(
    .CYCLES(WR_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(start),
    .busy(busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control byte decode
  always_comb begin
    pre = link.ctrl[ewp_pkg::PRE_MSB:ewp_pkg::PRE_LSB];
    adr = link.ctrl[ewp_pkg::ADR_MSB:ewp_pkg::ADR_LSB];
    rd = link.ctrl[ewp_pkg::RW_BIT]; // RQ19
    strap_match = (adr == {addr_strap_2, addr_strap_1, addr_strap_0}); // RQ19
    is_array = (pre == ewp_pkg::PRE_ARRAY) && strap_match; // RQ19
    // HV on strap 0 arrives as its own detect line
    is_rev_set = (link.ctrl[ewp_pkg::PRE_MSB:ewp_pkg::ADR_LSB]
      == ewp_pkg::CMD_REV_SET[ewp_pkg::PRE_MSB:ewp_pkg::ADR_LSB]) && addr_strap_0_hv
      && !addr_strap_2 && !addr_strap_1; // RQ6 RQ20
    is_rev_clr = (link.ctrl == ewp_pkg::CMD_REV_CLR) && addr_strap_0_hv
      && !addr_strap_2 && addr_strap_1; // RQ7 RQ20
    // Permanent commands use the ordinary strap match
    is_perm = (pre == ewp_pkg::PRE_LOCK) && strap_match && !addr_strap_0_hv; // RQ2
    // Floating pin reads as low on this input
    wp_hi = wp_at_supply; // RQ21
    lock_any = perm_r || rev_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command response and lock update
  always_comb begin
    loaded_nxt = 1'b1;
    perm_nxt = perm_r;
    rev_nxt = rev_r;
    rsp_valid_nxt = 1'b0;
    rsp_ack_nxt = rsp_ack_r;
    arr_we_nxt = 1'b0;
    arr_addr_nxt = arr_addr_r;
    arr_wdata_nxt = arr_wdata_r;
    nv_we_nxt = 1'b0;
    start = 1'b0;
    if (!loaded_r) begin
      // Restore flags from nonvolatile cells
      perm_nxt = nv_perm_stored; // RQ20
      rev_nxt = nv_rev_stored; // RQ20
    end else if (link.req) begin
      rsp_valid_nxt = 1'b1;
      rsp_ack_nxt = 1'b0;
      if (busy) begin
        // Inputs disabled during write cycle
        rsp_ack_nxt = 1'b0;
      end else if (is_array) begin
        rsp_ack_nxt = 1'b1; // RQ10 RQ11
        if (!rd) begin
          // Cycle runs even when nothing is written
          start = 1'b1; // RQ17
          arr_addr_nxt = link.waddr;
          arr_wdata_nxt = link.wdata;
          // Pin blocks all; locks block the lower half
          arr_we_nxt = !wp_hi
            && !(lock_any && ewp_pkg::ewp_in_lower(link.waddr)); // RQ1 RQ8 RQ9 RQ10 RQ11
        end
      end else if ((pre == ewp_pkg::PRE_LOCK) && perm_r) begin
        // Whole preamble silenced for good
        rsp_ack_nxt = 1'b0; // RQ5 RQ12 RQ13 RQ16
      end else if (is_rev_set) begin
        rsp_ack_nxt = !rev_r; // RQ14 RQ15
        if (!rd && !rev_r) begin
          start = 1'b1; // RQ17
          if (!wp_hi) begin
            rev_nxt = 1'b1; // RQ15 RQ6 RQ3
            nv_we_nxt = 1'b1;
          end
        end
      end else if (is_rev_clr) begin
        rsp_ack_nxt = 1'b1; // RQ16
        start = 1'b1;
        if (!wp_hi) begin
          rev_nxt = 1'b0; // RQ7 RQ3 RQ18
          nv_we_nxt = 1'b1;
        end
      end else if (is_perm) begin
        // Permanent lock known clear on this branch
        rsp_ack_nxt = 1'b1; // RQ12 RQ13
        if (!rd) begin
          // Word address and data are ignored
          start = 1'b1; // RQ2
          if (!wp_hi) begin
            perm_nxt = 1'b1; // RQ13 RQ3 RQ18
            nv_we_nxt = 1'b1;
          end
        end
      end
    end
    nv_perm_nxt = perm_nxt;
    nv_rev_nxt = rev_nxt;
  end

  // Registers, frozen while ce low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_r <= 1'b0;
      perm_r <= 1'b0;
      rev_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_ack_r <= 1'b0;
      arr_we_r <= 1'b0;
      arr_addr_r <= 8'h00;
      arr_wdata_r <= 8'h00;
      nv_we_r <= 1'b0;
      nv_perm_r <= 1'b0;
      nv_rev_r <= 1'b0;
    end else if (ce) begin
      loaded_r <= loaded_nxt;
      perm_r <= perm_nxt;
      rev_r <= rev_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_ack_r <= rsp_ack_nxt;
      arr_we_r <= arr_we_nxt;
      arr_addr_r <= arr_addr_nxt;
      arr_wdata_r <= arr_wdata_nxt;
      nv_we_r <= nv_we_nxt;
      nv_perm_r <= nv_perm_nxt;
      nv_rev_r <= nv_rev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.rsp_valid = rsp_valid_r;
  assign link.rsp_ack = rsp_ack_r;
  assign link.busy = busy;
  assign arr_we = arr_we_r;
  assign arr_addr = arr_addr_r;
  assign arr_wdata = arr_wdata_r;
  assign nv_we = nv_we_r;
  assign nv_perm_d = nv_perm_r;
  assign nv_rev_d = nv_rev_r;
  assign permanent_soft_lock = perm_r;
  assign reversible_soft_lock = rev_r;
endmodule // ewp_dev_end
`default_nettype wire

// [rtl/ewp_pkg.sv]
package ewp_pkg;
  // Control byte layout
  localparam int PRE_MSB = 7;
  localparam int PRE_LSB = 4;
  localparam int ADR_MSB = 3;
  localparam int ADR_LSB = 1;
  localparam int RW_BIT = 0;
  // Control byte preambles
  localparam logic [3:0] PRE_ARRAY = 4'hA;
  localparam logic [3:0] PRE_LOCK = 4'h6;
  // Reversible lock commands, write form
  localparam logic [7:0] CMD_REV_SET = 8'h62;
  localparam logic [7:0] CMD_REV_CLR = 8'h66;
  // First location of the upper half
  localparam logic [7:0] UPPER_BASE = 8'h80;
  // Timing: clock period and self-timed write cycle
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WR_TIME_NS = 1000000;
  localparam int WR_CYCLES = (WR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Controller register map
  localparam int APB_AW = 12;
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  // Command register fields
  localparam int CMD_CTRL_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_DATA_LSB = 16;
  // Status register fields
  localparam int STAT_PEND = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ACK = 2;
  localparam int STAT_DBUSY = 3;
  // Controller sequencing states
  typedef enum logic [1:0] {EWP_IDLE, EWP_WAIT_FREE, EWP_WAIT_RSP} ewp_host_st_t;
  // Lower half test used by the array write gate
  function automatic logic ewp_in_lower(input logic [7:0] a);
    return a < UPPER_BASE;
  endfunction
endpackage

// [rtl/ewp_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Command-level link between controller and protected memory
interface ewp_link_if;
  logic req; // One-cycle command strobe
  logic [7:0] ctrl; // Control byte
  logic [7:0] waddr; // Word address
  logic [7:0] wdata; // Data byte
  logic rsp_valid; // One-cycle answer strobe
  logic rsp_ack; // Acknowledge of the answer
  logic busy; // Self-timed write cycle running
  modport dev (input req, ctrl, waddr, wdata, output rsp_valid, rsp_ack, busy);
  modport ctl (output req, ctrl, waddr, wdata, input rsp_valid, rsp_ack, busy);
endinterface
`default_nettype wire

// [rtl/ewp_wr_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-timed write cycle counter
module ewp_wr_timer #(
  parameter int CYCLES = ewp_pkg::WR_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic start,
  output logic busy
);
  logic [31:0] cnt_r; // Cycles left
  logic [31:0] cnt_nxt;
  logic busy_r; // Cycle in progress
  logic busy_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Next count
  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    if (start && !busy_r) begin
      // Load full cycle
      cnt_nxt = 32'(CYCLES);
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      // Count down, drop on last
      cnt_nxt = cnt_r - 32'h0000_0001;
      busy_nxt = (cnt_r != 32'h0000_0001);
    end
  end

  // Registers, frozen while ce low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0000_0000;
      busy_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy = busy_r;
endmodule // ewp_wr_timer
`default_nettype wire

// [rtl/ewp_ctl_end.sv]
`timescale 1ns/1ps
`default_nettype none
// Controller end: APB registers drive one command at a time
module ewp_ctl_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ewp_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ewp_link_if.ctl link
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ewp_pkg::ewp_host_st_t st_r; // Sequencer state
  ewp_pkg::ewp_host_st_t st_nxt;
  logic [23:0] cmd_r; // Latched command fields
  logic [23:0] cmd_nxt;
  logic req_r; // Command strobe
  logic req_nxt;
  logic done_r; // Answer received
  logic done_nxt;
  logic ack_r; // Last answer acknowledged
  logic ack_nxt;
  logic pready_r; // Access completes
  logic pready_nxt;
  logic pslverr_r; // Access refused
  logic pslverr_nxt;
  logic [31:0] prdata_r; // Read data
  logic [31:0] prdata_nxt;
  logic acc; // First access cycle
  logic fire; // Completing write
  logic hit_cmd; // Command register addressed
  logic hit_stat; // Status register addressed

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and sequencer
  always_comb begin
    acc = psel && penable && !pready_r;
    fire = psel && penable && pwrite && pready_r;
    hit_cmd = (paddr == ewp_pkg::REG_CMD);
    hit_stat = (paddr == ewp_pkg::REG_STAT);
    pready_nxt = acc;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    req_nxt = 1'b0;
    done_nxt = done_r;
    ack_nxt = ack_r;
    if (acc) begin
      // Unmapped, status write, or command while one is pending
      pslverr_nxt = !(hit_cmd || hit_stat) || (hit_cmd && pwrite && st_r != ewp_pkg::EWP_IDLE)
        || (hit_stat && pwrite);
      if (!pwrite && hit_cmd) begin
        prdata_nxt[23:0] = cmd_r;
      end else if (!pwrite && hit_stat) begin
        prdata_nxt[ewp_pkg::STAT_PEND] = (st_r != ewp_pkg::EWP_IDLE);
        prdata_nxt[ewp_pkg::STAT_DONE] = done_r;
        prdata_nxt[ewp_pkg::STAT_ACK] = ack_r;
        prdata_nxt[ewp_pkg::STAT_DBUSY] = link.busy;
      end
    end
    unique case (st_r)
      ewp_pkg::EWP_IDLE: begin
        // New command clears the previous answer
        // Refused writes never load a command
        if (fire && hit_cmd && !pslverr_r) begin
          cmd_nxt = pwdata[23:0];
          done_nxt = 1'b0;
          st_nxt = ewp_pkg::EWP_WAIT_FREE;
        end
      end
      ewp_pkg::EWP_WAIT_FREE: begin
        // Hold off until write cycle is over
        if (!link.busy) begin // RQ4
          req_nxt = 1'b1;
          st_nxt = ewp_pkg::EWP_WAIT_RSP;
        end
      end
      ewp_pkg::EWP_WAIT_RSP: begin
        // Capture the answer
        if (link.rsp_valid) begin
          ack_nxt = link.rsp_ack;
          done_nxt = 1'b1;
          st_nxt = ewp_pkg::EWP_IDLE;
        end
      end
    endcase
  end

  // Registers, frozen while ce low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ewp_pkg::EWP_IDLE;
      cmd_r <= 24'h00_0000;
      req_r <= 1'b0;
      done_r <= 1'b0;
      ack_r <= 1'b0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (ce) begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      req_r <= req_nxt;
      done_r <= done_nxt;
      ack_r <= ack_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.req = req_r;
  assign link.ctrl = cmd_r[ewp_pkg::CMD_CTRL_LSB +: 8];
  assign link.waddr = cmd_r[ewp_pkg::CMD_ADDR_LSB +: 8];
  assign link.wdata = cmd_r[ewp_pkg::CMD_DATA_LSB +: 8];
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
endmodule // ewp_ctl_end
`default_nettype wire

// [verif/ewp_link_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// Link watcher
module ewp_link_asserts #(
  parameter int WR_CYCLES = ewp_pkg::WR_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [7:0] ctrl,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic busy,
  input wire logic ce
);
  int busy_cnt_r; // Busy cycles seen
  int busy_cnt_nxt; // Next count
  default clocking cb @(posedge pclk); endclocking
  // Frozen cycles are not judged
  default disable iff (!presetn || !ce);
  ////////////////////////////////////////
  // Count while busy, paused while frozen
  always_comb begin
    busy_cnt_nxt = busy_cnt_r;
    if (ce) begin
      busy_cnt_nxt = busy ? busy_cnt_r + 1 : 0;
    end
  end
  // Register the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end
  ////////////////////////////////////////
  // Command then answer
  sequence s_cmd;
    req ##1 rsp_valid;
  endsequence
  // Accepted answer
  sequence s_acked;
    rsp_valid && rsp_ack;
  endsequence
  ans_latency_a: assert property (req |-> s_cmd) else $error("answer late");
  ans_cause_a: assert property (rsp_valid |-> $past(req)) else $error("stray answer");
  ans_pulse_a: assert property (rsp_valid |=> !rsp_valid) else $error("answer too long");
  ack_hold_a: assert property (!rsp_valid |-> $stable(rsp_ack)) else $error("ack moved");
  cycle_start_a: assert property ($rose(busy) |-> s_acked) else $error("cycle w/o ack");
  cycle_len_a: assert property ($fell(busy) |-> busy_cnt_r == WR_CYCLES)
    else $error("cycle length");
  cycle_cap_a: assert property (busy_cnt_r <= WR_CYCLES) else $error("cycle overrun");
  write_cycle_a: assert property (req && !ctrl[0] ##1 s_acked |-> busy)
    else $error("acked write no cycle");
  cmd_hold_a: assert property (req |=> $stable({ctrl, waddr, wdata}))
    else $error("command moved");
  no_req_busy_a: assert property (req |-> !busy) else $error("req while busy");
  query_nocyc_a: assert property (req && ctrl[0] |=> !busy) else $error("read ran cycle");
  foreign_nack_a: assert property (req && ctrl[7:4] != ewp_pkg::PRE_ARRAY
    && ctrl[7:4] != ewp_pkg::PRE_LOCK |=> !rsp_ack) else $error("foreign acked");
endmodule // ewp_link_asserts
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int WRC = 8; // Short write cycle
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic s2, s1, s0, hv, wp; // Straps, HV, protect pin
  logic nv_p = 1'b0, nv_r = 1'b0, nv_we, nv_pd, nv_rd; // Cells
  logic ce, frz; // Clock enable, freeze request
  logic arr_we, plock, rlock, exp_p, exp_r;
  logic [7:0] arr_addr, arr_wdata;
  logic ack_q[$]; // Expected answers
  logic [15:0] we_q[$]; // Expected array writes
  int mismatches, tests_run;
  ewp_link_if u_ewp_link_if();
  ewp_ctl_end u_ewp_ctl_end (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(u_ewp_link_if));
  ewp_dev_end #(.WR_CYCLES(WRC)) u_ewp_dev_end (.pclk(pclk), .presetn(presetn), .ce(ce),
    .link(u_ewp_link_if), .addr_strap_2(s2), .addr_strap_1(s1), .addr_strap_0(s0),
    .addr_strap_0_hv(hv), .wp_at_supply(wp), .nv_perm_stored(nv_p), .nv_rev_stored(nv_r),
    .nv_we(nv_we), .nv_perm_d(nv_pd), .nv_rev_d(nv_rd), .arr_we(arr_we),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .permanent_soft_lock(plock),
    .reversible_soft_lock(rlock));
  ewp_link_asserts #(.WR_CYCLES(WRC)) u_ewp_link_asserts (.pclk(pclk), .presetn(presetn),
    .req(u_ewp_link_if.req), .ctrl(u_ewp_link_if.ctrl), .waddr(u_ewp_link_if.waddr),
    .wdata(u_ewp_link_if.wdata), .rsp_valid(u_ewp_link_if.rsp_valid),
    .rsp_ack(u_ewp_link_if.rsp_ack), .busy(u_ewp_link_if.busy), .ce(ce));
  ////////////////////////////////////////
  // Xorshift source
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Verdict and stop
  task automatic end_of_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Access lasts until pready; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issue one command, note expectations, poll until idle
  task automatic cmd(input logic [7:0] c, input logic ack, input logic we, input logic [7:0] a);
    logic [7:0] d;
    d = 8'(rnd());
    ack_q.push_back(ack);
    if (we) we_q.push_back({a, d});
    apb(1'b1, ewp_pkg::REG_CMD, {8'h00, d, a, c});
    if (frz) begin
      // Freeze inside the write cycle: busy must not run down
      repeat (4) @(posedge pclk);
      ce <= 1'b0;
      repeat (20) @(posedge pclk);
      chk("busy_frozen", 1, u_ewp_link_if.busy);
      ce <= 1'b1;
      frz = 1'b0;
    end
    do begin
      apb(1'b0, ewp_pkg::REG_STAT, 32'h0);
    end while (rd[ewp_pkg::STAT_DONE] !== 1'b1 || rd[ewp_pkg::STAT_DBUSY] !== 1'b0);
    chk("stat_ack", ack, rd[ewp_pkg::STAT_ACK]);
    chk("perm_lock", exp_p, plock);
    chk("rev_lock", exp_r, rlock);
  endtask
  // Array byte write, permission worked out from pin and flags
  task automatic arr_wr(input logic [7:0] a);
    cmd({ewp_pkg::PRE_ARRAY, s2, s1, s0, 1'b0}, 1'b1,
      !wp && (a >= ewp_pkg::UPPER_BASE || !(exp_p || exp_r)), a);
  endtask
  ////////////////////////////////////////
  // Clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Answer, array and cell watcher
  always @(posedge pclk) begin
    if (u_ewp_link_if.rsp_valid === 1'b1) begin
      if (ack_q.size() == 0) chk("extra_answer", 0, 1);
      else chk("rsp_ack", ack_q.pop_front(), u_ewp_link_if.rsp_ack);
    end
    if (arr_we === 1'b1) begin
      if (we_q.size() == 0) chk("extra_arr_we", 0, 1);
      else chk("arr_write", we_q.pop_front(), {arr_addr, arr_wdata});
    end
    if (nv_we === 1'b1) begin
      nv_p <= nv_pd;
      nv_r <= nv_rd;
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_of_test();
  end
  // Main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    ce = 1'b1;
    frz = 1'b0;
    s2 = 1'b0;
    s1 = 1'b0;
    s0 = 1'b0;
    hv = 1'b0;
    wp = 1'b0;
    exp_p = 1'b0;
    exp_r = 1'b0;
    mismatches = 0;
    tests_run = 0;
    seed = 32'h0000_B545;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'hFF0, 32'h0);
    chk("unmapped_err", 1, err);
    arr_wr(8'(rnd()) & 8'h7F);
    frz = 1'b1;
    arr_wr(8'(rnd()) | 8'h80);
    cmd({ewp_pkg::PRE_ARRAY, 4'b1000}, 1'b0, 1'b0, 8'h00);
    cmd({4'hB, 4'b0001}, 1'b0, 1'b0, 8'h00);
    cmd({ewp_pkg::PRE_ARRAY, 4'b0001}, 1'b1, 1'b0, 8'h00);
    s0 <= 1'b1;
    hv <= 1'b1;
    exp_r = 1'b1;
    cmd(ewp_pkg::CMD_REV_SET, 1'b1, 1'b0, 8'(rnd()));
    cmd(ewp_pkg::CMD_REV_SET, 1'b0, 1'b0, 8'(rnd()));
    cmd(ewp_pkg::CMD_REV_SET | 8'h01, 1'b0, 1'b0, 8'h00);
    arr_wr(8'(rnd()) & 8'h7F);
    arr_wr(8'h80);
    wp <= 1'b1;
    s1 <= 1'b1;
    cmd(ewp_pkg::CMD_REV_CLR, 1'b1, 1'b0, 8'h00);
    arr_wr(8'hFF);
    wp <= 1'b0;
    exp_r = 1'b0;
    cmd(ewp_pkg::CMD_REV_CLR, 1'b1, 1'b0, 8'h00);
    s1 <= 1'b0;
    cmd(ewp_pkg::CMD_REV_SET | 8'h01, 1'b1, 1'b0, 8'h00);
    s0 <= 1'b0;
    hv <= 1'b0;
    wp <= 1'b1;
    cmd({ewp_pkg::PRE_LOCK, 4'h0}, 1'b1, 1'b0, 8'h00);
    cmd({ewp_pkg::PRE_LOCK, 4'h1}, 1'b1, 1'b0, 8'h00);
    wp <= 1'b0;
    exp_p = 1'b1;
    cmd({ewp_pkg::PRE_LOCK, 4'h0}, 1'b1, 1'b0, 8'(rnd()));
    cmd({ewp_pkg::PRE_LOCK, 4'h0}, 1'b0, 1'b0, 8'(rnd()));
    cmd({ewp_pkg::PRE_LOCK, 4'h1}, 1'b0, 1'b0, 8'h00);
    arr_wr(8'(rnd()) & 8'h7F);
    s0 <= 1'b1;
    s1 <= 1'b1;
    hv <= 1'b1;
    cmd(ewp_pkg::CMD_REV_CLR, 1'b0, 1'b0, 8'h00);
    s1 <= 1'b0;
    cmd(ewp_pkg::CMD_REV_SET, 1'b0, 1'b0, 8'h00);
    // Power loss: flags come back from the cells
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("perm_after_reset", 1, plock);
    arr_wr(8'h7F);
    chk("queues_empty", 0, ack_q.size() + we_q.size());
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
